/* File: design/vtmr_pkg.sv */
// Shared constants and carrier types for the fixed-format video timer.
// Assumes one character time per clock cycle in which the clock enable is high.
package vtmr_pkg;

	// Horizontal format, in character times.
	localparam int H_ACTIVE = 80;
	localparam int H_FP = 6;
	localparam int H_SYNC = 8;
	localparam int H_BP = 6;
	localparam int H_TOTAL = H_ACTIVE + H_FP + H_SYNC + H_BP;
	localparam int H_COUNT = H_TOTAL - 1;

	// Vertical format, in scan lines.
	localparam int V_ROWS = 24;
	localparam int V_SCANS = 9;
	localparam int V_FP = 16;
	localparam int V_SYNC = 3;
	localparam int V_BP = 27;
	localparam int V_ACTIVE = V_ROWS * V_SCANS;
	localparam int V_TOTAL = V_ACTIVE + V_FP + V_SYNC + V_BP;
	localparam int V_START = V_SYNC + V_BP;

	// Skew of sync/blank and cursor against the character address, in character times.
	localparam int SKEW_SYNC = 0;
	localparam int SKEW_CURSOR = 0;

	// Character and dot rates that the outside clocking is expected to present.
	localparam int CHAR_RATE_HZ = 1572000;
	localparam int DOT_RATE_HZ = 11004000;
	localparam int DOTS_PER_CHAR = 7;

	// Counter widths.
	localparam int HW = 7;
	localparam int VW = 9;
	localparam int SW = 4;
	localparam int RW = 5;
	localparam int DW = 6;
	localparam int CW = 8;

	// Typed limits that the counters are compared with.
	localparam logic [HW-1:0] H_LAST = HW'(H_COUNT);
	localparam logic [HW-1:0] H_ACT_END = HW'(H_ACTIVE);
	localparam logic [HW-1:0] H_SYNC_BEG = HW'(H_ACTIVE + H_FP + SKEW_SYNC);
	localparam logic [HW-1:0] H_SYNC_LEN = HW'(H_SYNC);
	localparam logic [VW-1:0] V_LAST = VW'(V_TOTAL - 1);
	localparam logic [VW-1:0] V_ACT_END = VW'(V_ACTIVE);
	localparam logic [VW-1:0] V_SYNC_BEG = VW'(V_ACTIVE + V_FP);
	localparam logic [VW-1:0] V_SYNC_LEN = VW'(V_SYNC);
	localparam logic [SW-1:0] SCAN_LAST = SW'(V_SCANS - 1);
	localparam logic [DW-1:0] ROW_LAST = DW'(V_ROWS - 1);

	// Select codes of the command port.
	localparam logic [3:0] CMD_LOAD_LAST = 4'h6;
	localparam logic [3:0] CMD_READ_ROW = 4'h8;
	localparam logic [3:0] CMD_READ_CHAR = 4'h9;
	localparam logic [3:0] CMD_RESET = 4'hA;
	localparam logic [3:0] CMD_SCROLL = 4'hB;
	localparam logic [3:0] CMD_LOAD_CHAR = 4'hC;
	localparam logic [3:0] CMD_LOAD_ROW = 4'hD;
	localparam logic [3:0] CMD_START = 4'hE;

	// Bus map: a select code sits at four times its value, the status word apart.
	localparam int ADDR_W = 8;
	localparam int ADDR_CODE_LSB = 2;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h40;
	localparam int ST_LAST_LSB = 0;
	localparam int ST_FIRST_LSB = 8;
	localparam int ST_HELD_BIT = 16;
	localparam int ST_PEND_BIT = 17;

	typedef struct packed {
		logic valid;
		logic [3:0] code;
		logic [CW-1:0] data;
	} vtmr_cmd_t;

	typedef struct packed {
		logic [CW-1:0] cur_char;
		logic [DW-1:0] cur_row;
		logic [31:0] status;
	} vtmr_rd_t;

	typedef struct packed {
		logic [HW-1:0] char_addr;
		logic [SW-1:0] row_scan;
		logic [DW-1:0] data_row;
		logic hsync;
		logic vsync;
		logic blank;
		logic cursor;
	} vtmr_vid_t;

endpackage

/* File: design/vtmr_ahb.sv */
// AHB-Lite slave that turns bus writes into strobed commands and serves cursor reads.
// Assumes single word transfers; the clock enable stalls the bus through hreadyout.
module vtmr_ahb
	import vtmr_pkg::*;
(
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Bus side.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Core side.
	output vtmr_cmd_t cmd,
	input wire vtmr_rd_t rd
);

	typedef enum logic [1:0] {PH_IDLE, PH_WR, PH_RD, PH_RDY} vtmr_phase_t;

	typedef struct packed {
		vtmr_phase_t phase;
		logic [ADDR_W-1:0] addr;
		logic [31:0] rdata;
	} vtmr_ahb_st_t;

	vtmr_ahb_st_t s_reg, s_next;

	function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] a, input vtmr_rd_t r);
		logic [3:0] code;
		code = a[ADDR_CODE_LSB+3:ADDR_CODE_LSB];
		if (a == ADDR_STATUS) begin
			return r.status;
		end
		if (a[ADDR_W-1:ADDR_CODE_LSB+4] != '0) begin
			return '0;
		end
		if (code == CMD_READ_ROW) begin
			return {26'h0000000, r.cur_row};
		end
		if (code == CMD_READ_CHAR) begin
			return {24'h000000, r.cur_char};
		end
		return '0;
	endfunction

	always_comb begin
		s_next = s_reg;
		unique case (s_reg.phase)
			PH_RD: begin
				// The wait cycle lets a write in the previous data phase land first.
				s_next.rdata = rd_mux(s_reg.addr, rd);
				s_next.phase = PH_RDY;
			end
			PH_IDLE, PH_WR, PH_RDY: begin
				s_next.phase = PH_IDLE;
			end
		endcase
		if (hsel && hready && htrans[1]) begin
			s_next.addr = haddr[ADDR_W-1:0];
			s_next.phase = hwrite ? PH_WR : PH_RD;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '{phase: PH_IDLE, addr: '0, rdata: '0};
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// Only writes raise the strobe; reads are served from the cursor and status mux, and the address picks the code.
	always_comb begin
		cmd.valid = (s_reg.phase == PH_WR) && (s_reg.addr[ADDR_W-1:ADDR_CODE_LSB+4] == '0);
		cmd.code = s_reg.addr[ADDR_CODE_LSB+3:ADDR_CODE_LSB];
		cmd.data = hwdata[CW-1:0];
	end

	assign hreadyout = ce && (s_reg.phase != PH_RD);
	assign hrdata = s_reg.rdata;
	assign hresp = 1'b0;

endmodule

/* File: design/vtmr_top.sv */
// Fixed-format video timer: character, scan and row counters with sync, blank and cursor.
// Assumes one character time per REF_CLK cycle with CE high; CE low freezes everything.
// Commands and cursor accesses arrive over AHB-Lite.
// Function
// - Porch six, sync eight, porch six characters
// - Scan line lasts exactly 100 character times
// - Vertical porch 16, sync 3, porch 27
// - Non-interlaced frame of 262 scan lines
// - 24 rows of 9 scans each
// - 80 active character addresses per line
// - Display starts 30 lines after vsync edge
// - No skew on sync, blank or cursor
// - Only cursor registers reachable; format fixed; status word also reads last and first rows
// - Load-last command sets last row 23
// - Fixed horizontal count 99, line 100
// - Reset command homes and holds counters
// - Start releases chain one scan later
// - Up scroll advances first row, wrapping
// - Cursor written and read by distinct codes
//
// Decided for this implementation: the AHB-Lite register port and the address map.
module vtmr_top
	import vtmr_pkg::*;
(
	// Clock, reset and enable.
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic CE,
	// AHB-Lite slave.
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Video timing outputs.
	output logic [HW-1:0] CHAR_ADDR,
	output logic [SW-1:0] ROW_SCAN,
	output logic [DW-1:0] DATA_ROW,
	output logic HSYNC,
	output logic VSYNC,
	output logic BLANK,
	output logic CURSOR
);

	typedef struct packed {
		logic [HW-1:0] hcnt;
		logic [VW-1:0] vline;
		logic [SW-1:0] scan;
		logic [RW-1:0] row;
		logic [DW-1:0] first;
		logic [DW-1:0] last;
		logic [CW-1:0] cur_char;
		logic [DW-1:0] cur_row;
		logic held;
		logic rel_pend;
		logic [HW-1:0] rel_cnt;
		vtmr_vid_t vid;
	} vtmr_st_t;

	vtmr_st_t s_reg, s_next;
	vtmr_cmd_t cmd;
	vtmr_rd_t rd;

	function automatic logic in_win(input logic [VW-1:0] v, input logic [VW-1:0] lo, input logic [VW-1:0] len);
		return (v >= lo) && (v < lo + len);
	endfunction

	function automatic logic [DW-1:0] row_addr(input logic [DW-1:0] first, input logic [RW-1:0] row,
		input logic [DW-1:0] last);
		logic [DW:0] sum;
		sum = {1'b0, first} + {2'b00, row};
		if (sum > {1'b0, last}) begin
			sum = sum - ({1'b0, last} + 7'h01);
		end
		return sum[DW-1:0];
	endfunction

	vtmr_ahb u_ahb (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.ce(CE),
		.hsel(HSEL),
		.haddr(HADDR),
		.htrans(HTRANS),
		.hwrite(HWRITE),
		.hsize(HSIZE),
		.hwdata(HWDATA),
		.hready(HREADY),
		.hrdata(HRDATA),
		.hreadyout(HREADYOUT),
		.hresp(HRESP),
		.cmd(cmd),
		.rd(rd)
	);

	always_comb begin
		logic act;
		logic [DW-1:0] dr;
		act = 1'b0;
		dr = '0;
		s_next = s_reg;
		if (!s_reg.held) begin
			if (s_reg.hcnt == H_LAST) begin
				s_next.hcnt = '0;
				if (s_reg.vline == V_LAST) begin
					s_next.vline = '0;
					s_next.scan = '0;
					s_next.row = '0;
				end else begin
					s_next.vline = s_reg.vline + 9'h001;
					if (s_reg.vline < V_ACT_END) begin
						if (s_reg.scan == SCAN_LAST) begin
							s_next.scan = '0;
							s_next.row = s_reg.row + 5'h01;
						end else begin
							s_next.scan = s_reg.scan + 4'h1;
						end
					end
				end
			end else begin
				s_next.hcnt = s_reg.hcnt + 7'h01;
			end
		end else if (s_reg.rel_pend) begin
			// One full scan line passes between the start command and the release.
			if (s_reg.rel_cnt == H_LAST) begin
				s_next.held = 1'b0;
				s_next.rel_pend = 1'b0;
			end else begin
				s_next.rel_cnt = s_reg.rel_cnt + 7'h01;
			end
		end
		if (cmd.valid) begin
			unique case (cmd.code)
				CMD_LOAD_LAST: begin
					s_next.last = ROW_LAST;
				end
				CMD_RESET: begin
					s_next.hcnt = '0;
					s_next.vline = '0;
					s_next.scan = '0;
					s_next.row = '0;
					s_next.held = 1'b1;
					s_next.rel_pend = 1'b0;
				end
				CMD_SCROLL: begin
					s_next.first = (s_reg.first >= s_reg.last) ? '0 : s_reg.first + 6'h01;
				end
				CMD_LOAD_CHAR: begin
					s_next.cur_char = cmd.data;
				end
				CMD_LOAD_ROW: begin
					s_next.cur_row = cmd.data[DW-1:0];
				end
				CMD_START: begin
					if (s_reg.held && !s_reg.rel_pend) begin
						s_next.rel_pend = 1'b1;
						s_next.rel_cnt = '0;
					end
				end
				// Format register loads have no effect: the format is fixed.
				default: begin
				end
			endcase
		end
		// Outputs come from the same next state, so nothing is skewed against the address.
		act = !s_next.held && (s_next.hcnt < H_ACT_END) && (s_next.vline < V_ACT_END);
		dr = row_addr(s_next.first, s_next.row, s_next.last);
		s_next.vid.char_addr = act ? s_next.hcnt : '0;
		s_next.vid.row_scan = act ? s_next.scan : '0;
		s_next.vid.data_row = act ? dr : '0;
		s_next.vid.blank = !act;
		s_next.vid.hsync = !s_next.held && in_win({2'b00, s_next.hcnt}, {2'b00, H_SYNC_BEG}, {2'b00, H_SYNC_LEN});
		s_next.vid.vsync = !s_next.held && in_win(s_next.vline, V_SYNC_BEG, V_SYNC_LEN);
		s_next.vid.cursor = act && ({1'b0, s_next.hcnt} == s_next.cur_char) && (dr == s_next.cur_row);
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s_reg <= '0;
			s_reg.held <= 1'b1;
			s_reg.vid.blank <= 1'b1;
		end else if (CE) begin
			s_reg <= s_next;
		end
	end

	always_comb begin
		rd = '0;
		rd.cur_char = s_reg.cur_char;
		rd.cur_row = s_reg.cur_row;
		rd.status[ST_LAST_LSB +: DW] = s_reg.last;
		rd.status[ST_FIRST_LSB +: DW] = s_reg.first;
		rd.status[ST_HELD_BIT] = s_reg.held;
		rd.status[ST_PEND_BIT] = s_reg.rel_pend;
	end

	assign CHAR_ADDR = s_reg.vid.char_addr;
	assign ROW_SCAN = s_reg.vid.row_scan;
	assign DATA_ROW = s_reg.vid.data_row;
	assign HSYNC = s_reg.vid.hsync;
	assign VSYNC = s_reg.vid.vsync;
	assign BLANK = s_reg.vid.blank;
	assign CURSOR = s_reg.vid.cursor;

	// Lines counted since the leading edge of vertical sync, read only by the checks.
	// The count is trusted only once such an edge has passed since the chain was last held.
	logic [VW-1:0] vs_lines_reg;
	logic vs_valid_reg;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			vs_lines_reg <= '0;
			vs_valid_reg <= 1'b0;
		end else if (CE && s_reg.held) begin
			vs_valid_reg <= 1'b0;
		end else if (CE && s_reg.hcnt == H_LAST) begin
			vs_lines_reg <= (s_reg.vline == V_SYNC_BEG - 9'h001) ? '0 : vs_lines_reg + 9'h001;
			vs_valid_reg <= vs_valid_reg || (s_reg.vline == V_SYNC_BEG - 9'h001);
		end
	end

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);

	sequence seq_cmd(logic [3:0] c);
		CE && cmd.valid && cmd.code == c;
	endsequence

	sequence seq_release_due;
		CE && s_reg.held && s_reg.rel_pend && s_reg.rel_cnt == H_LAST && !cmd.valid;
	endsequence

	sequence seq_line_end;
		CE && !s_reg.held && !cmd.valid && s_reg.hcnt == H_LAST;
	endsequence

	a_line_wrap: assert property (CE && !s_reg.held && !cmd.valid && s_reg.hcnt == H_LAST |=> s_reg.hcnt == '0)
		else $error("line did not wrap after count 99");
	a_line_bound: assert property (s_reg.hcnt <= H_LAST)
		else $error("character counter beyond line length");
	a_hsync_start: assert property ($rose(HSYNC) |-> s_reg.hcnt == H_SYNC_BEG)
		else $error("hsync started at wrong character");
	a_hsync_stop: assert property ($fell(HSYNC) && !s_reg.held |-> s_reg.hcnt == H_SYNC_BEG + H_SYNC_LEN)
		else $error("hsync ended at wrong character");
	a_vsync_start: assert property ($rose(VSYNC) |-> s_reg.vline == V_SYNC_BEG && s_reg.hcnt == '0)
		else $error("vsync started on wrong line");
	a_frame_bound: assert property (s_reg.vline <= V_LAST)
		else $error("line counter beyond frame");
	a_active_start: assert property (vs_valid_reg && !BLANK && s_reg.vline == '0 && s_reg.hcnt == '0
		|-> vs_lines_reg == V_START)
		else $error("display did not start 30 lines after vsync");
	a_row_step: assert property (CE && !s_reg.held && !cmd.valid && s_reg.hcnt == H_LAST
		&& s_reg.scan == SCAN_LAST && s_reg.vline < V_ACT_END |=> s_reg.scan == '0
		&& s_reg.row == $past(s_reg.row) + 5'h01)
		else $error("row did not advance after nine scans");
	a_active_addr: assert property (!BLANK |-> CHAR_ADDR < H_ACT_END && CHAR_ADDR == s_reg.hcnt)
		else $error("active address out of range");
	a_cursor_align: assert property (CURSOR |-> !BLANK && {1'b0, CHAR_ADDR} == s_reg.cur_char
		&& DATA_ROW == s_reg.cur_row)
		else $error("cursor skewed against address");
	a_last_load: assert property (seq_cmd(CMD_LOAD_LAST) |=> s_reg.last == ROW_LAST)
		else $error("last row not loaded with 23");
	a_format_fixed: assert property (CE && cmd.valid && cmd.code < CMD_LOAD_LAST |=> $stable(s_reg.last)
		&& $stable(s_reg.first))
		else $error("format load changed a register");
	a_reset_hold: assert property (seq_cmd(CMD_RESET) |=> s_reg.held && s_reg.hcnt == '0 && s_reg.vline == '0
		##1 (s_reg.held || $past(s_reg.rel_pend)))
		else $error("reset command did not home and hold");
	a_start_release: assert property (seq_release_due |=> !s_reg.held
		##1 (s_reg.hcnt == 7'h01 || !$past(CE) || $past(cmd.valid)))
		else $error("start did not release after one line");
	a_scroll_wrap: assert property (seq_cmd(CMD_SCROLL) ##0 s_reg.first >= s_reg.last |=> s_reg.first == '0)
		else $error("scroll did not wrap to top");
	a_cursor_load: assert property (seq_cmd(CMD_LOAD_CHAR) |=> s_reg.cur_char == $past(cmd.data))
		else $error("cursor character not loaded");
	a_hcnt_step: assert property (CE && !s_reg.held && !cmd.valid && s_reg.hcnt != H_LAST
		|=> s_reg.hcnt == $past(s_reg.hcnt) + 7'h01)
		else $error("character counter skipped a step");
	a_vline_step: assert property (seq_line_end ##0 s_reg.vline != V_LAST
		|=> s_reg.vline == $past(s_reg.vline) + 9'h001)
		else $error("line counter skipped a line");
	a_frame_wrap: assert property (seq_line_end ##0 s_reg.vline == V_LAST
		|=> s_reg.vline == '0 && s_reg.row == '0)
		else $error("frame did not wrap after 262 lines");
	a_vsync_stop: assert property ($fell(VSYNC) && !s_reg.held
		|-> s_reg.vline == V_SYNC_BEG + V_SYNC_LEN && s_reg.hcnt == '0)
		else $error("vsync ended on wrong line");
	a_held_quiet: assert property (s_reg.held |-> BLANK && !HSYNC && !VSYNC && !CURSOR)
		else $error("held chain drove sync, cursor or display");
	a_blank_vert: assert property (s_reg.vline >= V_ACT_END |-> BLANK)
		else $error("display active beyond the last row");
	a_scan_bound: assert property (s_reg.scan <= SCAN_LAST)
		else $error("scan counter beyond nine scans");
	a_hsync_window: assert property (HSYNC |-> !s_reg.held && s_reg.hcnt >= H_SYNC_BEG
		&& s_reg.hcnt < H_SYNC_BEG + H_SYNC_LEN)
		else $error("hsync outside its window");
	a_scroll_step: assert property (seq_cmd(CMD_SCROLL) ##0 s_reg.first < s_reg.last
		|=> s_reg.first == $past(s_reg.first) + 6'h01)
		else $error("scroll did not advance first row");
	a_row_load: assert property (seq_cmd(CMD_LOAD_ROW) |=> s_reg.cur_row == $past(cmd.data[DW-1:0]))
		else $error("cursor row not loaded");
	a_start_pend: assert property (seq_cmd(CMD_START) ##0 s_reg.held && !s_reg.rel_pend
		|=> s_reg.rel_pend && s_reg.held && s_reg.rel_cnt == '0)
		else $error("start did not arm the release");

endmodule

/* File: bench/vtmr_host.sv */
// Host model: an AHB-Lite master that issues single word commands and cursor reads.
// Assumes the slave's hreadyout is the bus hready and that tasks start just after a rising edge.
module vtmr_host (
	// Clock.
	input wire logic clk,
	// Bus.
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	// Read result, announced by a toggle.
	output logic rd_tog,
	output logic [31:0] rd_word
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		rd_tog = 1'b0;
		rd_word = 32'h0;
	end

	// One transfer; the released data bus shows the inverse of the last word.
	task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge clk iff hready);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk iff hready);
		rd_word <= hrdata;
		rd_tog <= rd_tog ^ !wr;
		hwdata <= ~d;
	endtask
endmodule

/* File: bench/vtmr_top_bench.sv */
// Self-checking bench for the fixed-format video timer.
// Assumes a host model on the bus and a random character-time enable.
module vtmr_top_bench
	import vtmr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b0;
	logic tick = 1'b0;
	logic arm = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, rd_tog;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd_word;
	logic [HW-1:0] char_addr;
	logic [SW-1:0] row_scan;
	logic [DW-1:0] data_row;
	logic hsync, vsync, blank, cursor;
	logic hs_p, vs_p, bl_p;
	logic [7:0] cur_c = 8'h00;
	logic [5:0] cur_r = 6'h00;
	logic [31:0] exp_q[$];
	int error_cnt = 0;
	int num_checks = 0;
	int hc, bc, lc, lf, al, ac, vs_n;
	int fr = 0;
	bit hs_seen, vs_seen;

	vtmr_top dut (.REF_CLK(ref_clk), .RST_N(rst_n), .CE(ce), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .CHAR_ADDR(char_addr), .ROW_SCAN(row_scan),
		.DATA_ROW(data_row), .HSYNC(hsync), .VSYNC(vsync), .BLANK(blank), .CURSOR(cursor));

	vtmr_host host (.clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .rd_tog(rd_tog), .rd_word(rd_word));

	always #50 ref_clk = ~ref_clk;
	// Each enabled cycle is one character time; the rate is compressed to keep the run short.
	always @(posedge ref_clk) ce <= ($urandom() % 4) != 0;
	always @(posedge ref_clk) tick <= ce;

	task automatic fail(input string m);
		error_cnt++;
		$display("[FAIL] %0t %s", $time, m);
	endtask

	task automatic chk(input bit ok, input string m);
		num_checks++;
		if (!ok) fail(m);
	endtask

	task automatic report_and_stop;
		$display("errors %0d checks %0d", error_cnt, num_checks);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	function automatic logic [31:0] st(input int l, input int f, input bit h, input bit p);
		return 32'(l) | (32'(f) << ST_FIRST_LSB) | (32'(h) << ST_HELD_BIT) | (32'(p) << ST_PEND_BIT);
	endfunction

	task automatic wr(input logic [3:0] c, input logic [7:0] d);
		host.xfer({2'h0, c, 2'h0}, 1'b1, {24'($urandom()), d});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		host.xfer(a, 1'b0, 32'h0);
	endtask

	// Read results are compared against the oldest expectation.
	always @(rd_tog) begin
		if (exp_q.size() > 0) begin
			if (rd_word !== exp_q[0] || hresp !== 1'b0) fail("read data");
			num_checks++;
			void'(exp_q.pop_front());
		end
	end

	// Video monitor: one sample per character time, counters in character times and lines.
	always @(negedge ref_clk) begin
		if (!arm) begin
			hc = 0;
			bc = 999;
			lc = 0;
			lf = 0;
			al = 0;
			ac = 0;
			hs_seen = 0;
			vs_seen = 0;
			hs_p = 1'b0;
			vs_p = 1'b0;
			bl_p = 1'b1;
		end else if (tick) begin
			hc++;
			bc++;
			chk(cursor === (!blank && {1'b0, char_addr} == cur_c && data_row == cur_r), "cursor");
			if (!blank) begin
				chk(char_addr === HW'(ac), "character address");
				ac++;
			end
			if (blank && !bl_p) begin
				chk(ac == H_ACTIVE, "active width");
				ac = 0;
				bc = 0;
			end
			if (!blank && bl_p) begin
				if (hs_seen) chk(hc == H_SYNC + H_BP, "back porch");
				if (vs_seen && al == 0) chk(lc == V_START, "vertical start");
				chk(row_scan === SW'(al % V_SCANS), "row scan");
				chk(data_row === DW'((fr + al / V_SCANS) % V_ROWS), "data row");
				al++;
				lf = 0;
			end
			if (hsync && !hs_p) begin
				if (hs_seen) chk(hc == H_TOTAL, "line length");
				if (bc < H_TOTAL) chk(bc == H_FP, "front porch");
				hc = 0;
				bc = 999;
				hs_seen = 1;
				lc++;
				lf++;
			end
			if (!hsync && hs_p) chk(hc == H_SYNC, "horizontal sync");
			if (vsync && !vs_p) begin
				if (vs_seen) chk(lc == V_TOTAL, "frame length");
				chk(al == V_ACTIVE && lf == V_FP + 1, "active lines");
				lc = 0;
				al = 0;
				vs_seen = 1;
				vs_n++;
			end
			if (!vsync && vs_p) chk(lc == V_SYNC, "vertical sync");
			hs_p = hsync;
			vs_p = vsync;
			bl_p = blank;
		end
	end

	initial begin
		repeat (90000) @(posedge ref_clk);
		fail("timeout");
		report_and_stop;
	end

	initial begin
		int n;
		void'($urandom(32'hCF291758));
		vs_n = 0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(ADDR_STATUS, st(0, 0, 1, 0));
		wr(CMD_RESET, 8'h00);
		wr(CMD_LOAD_LAST, 8'h00);
		rd(ADDR_STATUS, st(23, 0, 1, 0));
		cur_c = 8'($urandom() % H_ACTIVE);
		cur_r = 6'($urandom() % V_ROWS);
		wr(CMD_LOAD_CHAR, cur_c);
		wr(CMD_LOAD_ROW, {2'h0, cur_r});
		rd({2'h0, CMD_READ_CHAR, 2'h0}, 32'(cur_c));
		rd({2'h0, CMD_READ_ROW, 2'h0}, 32'(cur_r));
		for (int i = 0; i < 6; i++) wr(4'(i), 8'($urandom()));
		rd(ADDR_STATUS, st(23, 0, 1, 0));
		rd(8'h3C, 32'h0);
		arm = 1'b1;
		wr(CMD_START, 8'h00);
		rd(ADDR_STATUS, st(23, 0, 1, 1));
		n = 0;
		while (blank !== 1'b0 && n < 300) begin
			@(posedge ref_clk);
			n += int'(ce);
		end
		chk(n >= 90 && n <= 105, "release delay");
		while (vs_n < 2) @(posedge ref_clk);
		for (int i = 1; i <= 24; i++) begin
			wr(CMD_SCROLL, 8'h00);
			fr = (fr + 1) % V_ROWS;
			if (i == 1 || i > 22) rd(ADDR_STATUS, st(23, i % 24, 0, 0));
		end
		arm = 1'b0;
		wr(CMD_RESET, 8'h00);
		rd(ADDR_STATUS, st(23, 0, 1, 0));
		repeat (150) @(posedge ref_clk);
		chk(blank === 1'b1 && hsync === 1'b0 && vsync === 1'b0 && char_addr === '0, "held outputs");
		report_and_stop;
	end
endmodule
